// *** shared/tga_defines.svh ***
// Constants of the contactless tag activation block.
`ifndef TGA_DEFINES_SVH
`define TGA_DEFINES_SVH
`define TGA_CMD_REQA 8'h26
`define TGA_CMD_WUPA 8'h52
`define TGA_CMD_CL1 8'h93
`define TGA_CMD_CL2 8'h95
`define TGA_NVB_ANTICOLL 8'h20
`define TGA_NVB_SELECT 8'h70
`define TGA_CMD_HLTA 8'h50
`define TGA_CMD_READ 8'h30
`define TGA_CMD_FAST_READ 8'h3A
`define TGA_CMD_WRITE 8'hA2
`define TGA_CMD_COMP_WRITE 8'hA0
`define TGA_CMD_READ_CNT 8'h39
`define TGA_CMD_READ_SIG 8'h3C
`define TGA_CMD_GET_VERSION 8'h60
`define TGA_CMD_PWD_VERIFY 8'h1B
`define TGA_CASCADE_TAG 8'h88
`define TGA_CRC_PRESET 16'h6363
`define TGA_CRC_POLY_REV 16'h8408
`define TGA_RX_MAX_BITS 9'h0A3
`define TGA_TX_MAX_BITS 9'h133
`define TGA_SHORT_FRAME_BITS 9'h008
`define TGA_PARITY_POS 4'h8
`define TGA_LEN_ANTICOLL 5'h02
`define TGA_LEN_SELECT 5'h09
`define TGA_LEN_HLTA 5'h04
`define TGA_LEN_READ 5'h04
`define TGA_LEN_PWD 5'h07
`define TGA_RX_KEEP 7
`endif

// *** shared/tga_pkg.sv ***
// Types shared by the tag activation block.
`default_nettype none
package tga_pkg;
   typedef enum logic [2:0] {
      TGA_IDLE,
      TGA_READY1,
      TGA_READY2,
      TGA_ACTIVE,
      TGA_AUTH,
      TGA_HALT
   } tga_state_t;
endpackage
`default_nettype wire

// *** src/tga_crc.sv ***
// Bit-serial 16-bit link CRC, LSB first, reflected polynomial.
`include "tga_defines.svh"
`default_nettype none
module tga_crc (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic clear,
   input wire logic bit_en,
   input wire logic bit_in,
   // Result
   output logic [15:0] crc
);
   wire fb = bit_in ^ crc[0];
   wire [15:0] next_crc = {1'b0, crc[15:1]} ^ (fb ? `TGA_CRC_POLY_REV : 16'h0000);

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         crc <= `TGA_CRC_PRESET;
      end else if (bit_en) begin
         crc <= next_crc;
      end
   end
endmodule
`default_nettype wire

// *** src/tga_tag.sv ***
// Protocol state machine and framing of a passive Type A tag.
// Behaviour
// - Reset enters IDLE, IDLE is wait state.
// - IDLE leaves only on REQA or WUPA.
// - Good HLTA makes HALT the wait state.
// - HALT leaves only on WUPA.
// - Level 1 SELECT moves READY1 to READY2.
// - READ address 0 in READY1 reaches ACTIVE.
// - READY1 error returns to wait state.
// - READY2 answers level 2 anticollision.
// - READ address 0 in READY2 reaches ACTIVE.
// - Level 2 SELECT answered with completion acknowledge.
// - READY2 error returns to wait state.
// - ACTIVE passes memory ops, HLTA halts.
// - Good password verify moves ACTIVE to AUTHENTICATED.
// - AUTHENTICATED grants protected page access.
// - AUTHENTICATED: HLTA halts, error to wait.
// - Start bit, odd parity, LSB first.
// - Multi-byte fields travel low byte first.
// - Frame length limits 163 and 307 bits.
// - Reader sizes bulk read to its frame.
// - CRC, parity, bit count, coding checked.
// - Only reader initiates; answer depends on state.
// - Check bytes are XOR of the four bytes before them, cascade tag included.
`include "tga_defines.svh"
`default_nettype none
module tga_tag
   import tga_pkg::*;
#(
   // Identifier, byte 0 first; the value is arbitrary.
   parameter logic [55:0] UID = 56'h66_55_44_33_22_11_0A,
   parameter logic [15:0] ATQA = 16'h0044,
   parameter logic [7:0] SAK_CL1 = 8'h04,
   parameter logic [7:0] SAK_CL2 = 8'h00
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // Link from the reader
   input wire logic LINK_CLK,
   input wire logic LINK_FRAME,
   input wire logic LINK_RX,
   input wire logic LINK_NOINFO,
   // Link to the reader
   output logic LINK_TX_FRAME,
   output logic LINK_TX_DATA,
   // Memory side
   input wire logic [31:0] PWD_VALUE,
   output logic MEM_CMD_VALID,
   output logic [7:0] MEM_CMD_OP,
   output logic [7:0] MEM_CMD_ARG,
   output logic MEM_CMD_AUTH,
   // Status
   output logic [2:0] TAG_STATE
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic lclk_d;
   logic frame_d;
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         lclk_d <= 1'b0;
         frame_d <= 1'b0;
      end else begin
         sync1 <= {LINK_NOINFO, LINK_RX, LINK_FRAME, LINK_CLK};
         sync2 <= sync1;
         lclk_d <= sync2[0];
         frame_d <= sync2[1];
      end
   end
   wire lk_rise = sync2[0] & ~lclk_d;
   wire rx_in = sync2[2];
   wire frame_end = frame_d & ~sync2[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver. Frames arriving while the tag answers are ignored, since the
   // reader never speaks before the tag has finished.
   tga_state_t state;
   logic halt_wait;
   logic tx_busy;
   logic [8:0] rx_bits;
   logic [3:0] rx_pos;
   logic [4:0] rx_nbytes;
   logic [7:0] rx_shift;
   logic rx_err;
   logic [7:0] rx_buf [0:`TGA_RX_KEEP-1];
   logic [15:0] rx_crc;
   wire rx_evt = lk_rise & sync2[1] & ~tx_busy;
   wire rx_data_bit = rx_evt && rx_bits != 9'h000 && rx_pos != `TGA_PARITY_POS;
   wire eval = frame_end && rx_bits != 9'h000 && !tx_busy;
   wire par_bad = (^rx_shift ^ rx_in) != 1'b1;
   wire start_bad = rx_bits == 9'h000 && !rx_in;
   wire too_long = rx_bits >= `TGA_RX_MAX_BITS;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || eval || frame_end) begin
         rx_bits <= 9'h000;
         rx_pos <= 4'h0;
         rx_nbytes <= 5'h00;
         rx_err <= 1'b0;
      end else if (rx_evt) begin
         rx_bits <= too_long ? rx_bits : rx_bits + 9'h001;
         rx_err <= rx_err | sync2[3] | start_bad | too_long;
         if (rx_bits != 9'h000 && rx_pos == `TGA_PARITY_POS) begin
            rx_err <= rx_err | sync2[3] | too_long | par_bad;
            rx_pos <= 4'h0;
            rx_nbytes <= rx_nbytes + 5'h01;
         end else if (rx_bits != 9'h000) begin
            rx_shift <= {rx_in, rx_shift[7:1]};
            rx_pos <= rx_pos + 4'h1;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `TGA_RX_KEEP; gi++) begin : g_rxbuf
         always_ff @(posedge CORE_CLK) begin
            if (rx_evt && rx_pos == `TGA_PARITY_POS && rx_nbytes == 5'(gi)) begin
               rx_buf[gi] <= rx_shift;
            end
         end
      end
   endgenerate

   tga_crc u_rx_crc (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .clear(eval | frame_end),
      .bit_en(rx_data_bit),
      .bit_in(rx_in),
      .crc(rx_crc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode.
   wire [7:0] u0 = UID[7:0];
   wire [7:0] u1 = UID[15:8];
   wire [7:0] u2 = UID[23:16];
   wire [7:0] u3 = UID[31:24];
   wire [7:0] u4 = UID[39:32];
   wire [7:0] u5 = UID[47:40];
   wire [7:0] u6 = UID[55:48];
   wire [7:0] bcc0 = `TGA_CASCADE_TAG ^ u0 ^ u1 ^ u2;
   wire [7:0] bcc1 = u3 ^ u4 ^ u5 ^ u6;
   wire [7:0] b0 = rx_buf[0];
   wire [7:0] b1 = rx_buf[1];
   wire is_short = rx_bits == `TGA_SHORT_FRAME_BITS && !rx_err;
   wire [7:0] short_cmd = {1'b0, rx_shift[7:1]};
   wire is_reqa = is_short && short_cmd == `TGA_CMD_REQA;
   wire is_wupa = is_short && short_cmd == `TGA_CMD_WUPA;
   wire full = !is_short && !rx_err && rx_pos == 4'h0;
   wire crc_ok = full && rx_crc == 16'h0000 && rx_nbytes > 5'h02;
   wire [39:0] sel_body = {rx_buf[6], rx_buf[5], rx_buf[4], rx_buf[3], rx_buf[2]};
   wire anti1 = full && rx_nbytes == `TGA_LEN_ANTICOLL && b0 == `TGA_CMD_CL1
      && b1 == `TGA_NVB_ANTICOLL;
   wire anti2 = full && rx_nbytes == `TGA_LEN_ANTICOLL && b0 == `TGA_CMD_CL2
      && b1 == `TGA_NVB_ANTICOLL;
   wire sel_len = crc_ok && rx_nbytes == `TGA_LEN_SELECT && b1 == `TGA_NVB_SELECT;
   wire sel1 = sel_len && b0 == `TGA_CMD_CL1
      && sel_body == {bcc0, u2, u1, u0, `TGA_CASCADE_TAG};
   wire sel2 = sel_len && b0 == `TGA_CMD_CL2 && sel_body == {bcc1, u6, u5, u4, u3};
   wire hlta = crc_ok && rx_nbytes == `TGA_LEN_HLTA && b0 == `TGA_CMD_HLTA
      && b1 == 8'h00;
   wire read0 = crc_ok && rx_nbytes == `TGA_LEN_READ && b0 == `TGA_CMD_READ
      && b1 == 8'h00;
   wire [31:0] pwd_rx = {rx_buf[4], rx_buf[3], rx_buf[2], rx_buf[1]};
   wire pwd_ok = crc_ok && rx_nbytes == `TGA_LEN_PWD && b0 == `TGA_CMD_PWD_VERIFY
      && pwd_rx == PWD_VALUE;
   // Range reads go out unchecked in length; the reader must size the range.
   wire mem_op = crc_ok && (b0 == `TGA_CMD_READ || b0 == `TGA_CMD_FAST_READ
      || b0 == `TGA_CMD_WRITE || b0 == `TGA_CMD_COMP_WRITE || b0 == `TGA_CMD_READ_CNT
      || b0 == `TGA_CMD_READ_SIG || b0 == `TGA_CMD_GET_VERSION);
   wire tga_state_t wait_state = halt_wait ? TGA_HALT : TGA_IDLE;

   ////////////////////////////////////////////////////////////////////////////////
   // State walk. Every move is caused by a reader frame; the tag never starts.
   tga_state_t next_state;
   logic next_halt;
   logic load_tx;
   logic fire_mem;
   logic [55:0] next_tx;
   logic [2:0] next_len;
   logic next_crc_on;
   always_comb begin
      next_state = state;
      next_halt = halt_wait;
      load_tx = 1'b0;
      fire_mem = 1'b0;
      next_tx = 56'h0;
      next_len = 3'h0;
      next_crc_on = 1'b0;
      if (eval) begin
         unique case (state)
            TGA_IDLE, TGA_HALT: begin
               if (is_wupa || (is_reqa && state == TGA_IDLE)) begin
                  next_state = TGA_READY1;
                  load_tx = 1'b1;
                  next_tx = {40'h0, ATQA};
                  next_len = 3'h2;
               end
            end
            TGA_READY1: begin
               if (anti1) begin
                  load_tx = 1'b1;
                  next_tx = {16'h0, bcc0, u2, u1, u0, `TGA_CASCADE_TAG};
                  next_len = 3'h5;
               end else if (sel1) begin
                  next_state = TGA_READY2;
                  load_tx = 1'b1;
                  next_tx = {48'h0, SAK_CL1};
                  next_len = 3'h1;
                  next_crc_on = 1'b1;
               end else if (read0) begin
                  next_state = TGA_ACTIVE;
                  fire_mem = 1'b1;
               end else begin
                  next_state = wait_state;
               end
            end
            TGA_READY2: begin
               if (anti2) begin
                  load_tx = 1'b1;
                  next_tx = {16'h0, bcc1, u6, u5, u4, u3};
                  next_len = 3'h5;
               end else if (sel2) begin
                  next_state = TGA_ACTIVE;
                  load_tx = 1'b1;
                  next_tx = {48'h0, SAK_CL2};
                  next_len = 3'h1;
                  next_crc_on = 1'b1;
               end else if (read0) begin
                  next_state = TGA_ACTIVE;
                  fire_mem = 1'b1;
               end else begin
                  next_state = wait_state;
               end
            end
            TGA_ACTIVE, TGA_AUTH: begin
               if (hlta) begin
                  next_state = TGA_HALT;
                  next_halt = 1'b1;
               end else if (pwd_ok && state == TGA_ACTIVE) begin
                  next_state = TGA_AUTH;
               end else if (mem_op) begin
                  fire_mem = 1'b1;
               end else begin
                  next_state = wait_state;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state <= TGA_IDLE;
         halt_wait <= 1'b0;
         MEM_CMD_VALID <= 1'b0;
         MEM_CMD_OP <= 8'h00;
         MEM_CMD_ARG <= 8'h00;
         MEM_CMD_AUTH <= 1'b0;
      end else begin
         state <= next_state;
         halt_wait <= next_halt;
         MEM_CMD_VALID <= fire_mem;
         if (fire_mem) begin
            MEM_CMD_OP <= b0;
            MEM_CMD_ARG <= b1;
            MEM_CMD_AUTH <= state == TGA_AUTH;
         end
      end
   end
   assign TAG_STATE = state;

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter. Answers are short, so the 307-bit ceiling is never reached.
   logic [55:0] tx_buf;
   logic [2:0] tx_len;
   logic tx_crc_on;
   logic [2:0] tx_idx;
   logic [3:0] tx_pos;
   logic tx_first;
   logic [15:0] tx_crc;
   wire [2:0] tx_total = tx_len + (tx_crc_on ? 3'h2 : 3'h0);
   wire [7:0] tx_cur = tx_idx < tx_len ? tx_buf[{tx_idx, 3'b000} +: 8]
      : (tx_idx == tx_len ? tx_crc[7:0] : tx_crc[15:8]);
   wire tx_step = lk_rise & tx_busy & ~tx_first & (tx_idx != tx_total);
   wire tx_feed = tx_step && tx_idx < tx_len && tx_pos != `TGA_PARITY_POS;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         tx_busy <= 1'b0;
         tx_first <= 1'b0;
         tx_idx <= 3'h0;
         tx_pos <= 4'h0;
         tx_len <= 3'h0;
         tx_crc_on <= 1'b0;
         tx_buf <= 56'h0;
         LINK_TX_FRAME <= 1'b0;
         LINK_TX_DATA <= 1'b0;
      end else if (load_tx) begin
         tx_busy <= 1'b1;
         tx_first <= 1'b1;
         tx_idx <= 3'h0;
         tx_pos <= 4'h0;
         tx_len <= next_len;
         tx_crc_on <= next_crc_on;
         tx_buf <= next_tx;
      end else if (lk_rise && tx_busy) begin
         if (tx_first) begin
            tx_first <= 1'b0;
            LINK_TX_FRAME <= 1'b1;
            LINK_TX_DATA <= 1'b1;
         end else if (tx_idx == tx_total) begin
            tx_busy <= 1'b0;
            LINK_TX_FRAME <= 1'b0;
            LINK_TX_DATA <= 1'b0;
         end else if (tx_pos == `TGA_PARITY_POS) begin
            LINK_TX_DATA <= ~^tx_cur;
            tx_pos <= 4'h0;
            tx_idx <= tx_idx + 3'h1;
         end else begin
            LINK_TX_DATA <= tx_cur[tx_pos[2:0]];
            tx_pos <= tx_pos + 4'h1;
         end
      end
   end

   tga_crc u_tx_crc (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .clear(load_tx),
      .bit_en(tx_feed),
      .bit_in(tx_cur[tx_pos[2:0]]),
      .crc(tx_crc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   reset_idle_a: assert property ($fell(SYS_RST) |-> state == TGA_IDLE && !halt_wait)
      else $error("state not idle after reset");
   idle_hold_a: assert property (eval && state == TGA_IDLE && !is_reqa && !is_wupa
      |=> state == TGA_IDLE) else $error("idle left without request");
   halt_wait_a: assert property ((state == TGA_ACTIVE || state == TGA_AUTH) && eval && hlta
      |=> state == TGA_HALT && halt_wait) else $error("halt not taken");
   halt_hold_a: assert property (eval && state == TGA_HALT && !is_wupa
      |=> state == TGA_HALT) else $error("halt left without wake");
   select_one_a: assert property (eval && state == TGA_READY1 && sel1
      |=> state == TGA_READY2 && tx_buf[7:0] == SAK_CL1) else $error("level 1 select");
   read_zero_a: assert property (eval && (state == TGA_READY1 || state == TGA_READY2)
      && read0 |=> state == TGA_ACTIVE && MEM_CMD_VALID ##1 !MEM_CMD_VALID)
      else $error("read 0 shortcut");
   ready_err_a: assert property (eval && state == TGA_READY1 && !anti1 && !sel1 && !read0
      |=> state == $past(wait_state)) else $error("error return wrong");
   auth_move_a: assert property (eval && state == TGA_ACTIVE && pwd_ok && !hlta
      |=> state == TGA_AUTH) else $error("password verify ignored");
   sak_two_a: assert property (eval && state == TGA_READY2 && sel2
      |=> tx_buf[7:0] == SAK_CL2 && tx_crc_on && tx_busy) else $error("completion ack");
   auth_mem_a: assert property (fire_mem && state == TGA_AUTH
      |=> MEM_CMD_VALID && MEM_CMD_AUTH) else $error("auth access flag");

   seen_ready2_c: cover property (state == TGA_READY1 ##1 state == TGA_READY2);
   seen_auth_c: cover property (state == TGA_ACTIVE ##1 state == TGA_AUTH);
   seen_halt_c: cover property (state == TGA_HALT ##1 state == TGA_READY1);
   seen_tx_c: cover property ($fell(LINK_TX_FRAME));
endmodule
`default_nettype wire

// *** dv/tga_reader_model.sv ***
// Reader model that frames commands to the tag and collects its answers.
`default_nettype none
module tga_reader_model (
   // Link toward the tag
   output logic LINK_CLK,
   output logic LINK_FRAME,
   output logic LINK_RX,
   output logic LINK_NOINFO,
   // Link from the tag
   input wire logic LINK_TX_FRAME,
   input wire logic LINK_TX_DATA
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HALF = 62.5;
   logic bq[$];
   logic [7:0] txb[$];
   logic [7:0] rsp[$];
   logic rsp_bad = 1'h0;
   logic start_val = 1'h1;
   int ni_at = -1;
   initial begin
      LINK_CLK = 1'h0;
      LINK_FRAME = 1'h0;
      LINK_RX = 1'h0;
      LINK_NOINFO = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'h6363;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      return c;
   endfunction
   // A set flip breaks the parity of this byte on purpose.
   task automatic put_byte(input logic [7:0] b, input logic flip = 1'h0);
      for (int k = 0; k < 8; k++) bq.push_back(b[k]);
      bq.push_back(~^b ^ flip);
      txb.push_back(b);
   endtask
   task automatic put_short(input logic [7:0] b);
      for (int k = 0; k < 7; k++) bq.push_back(b[k]);
   endtask
   task automatic put_crc(input logic flip = 1'h0);
      logic [15:0] c;
      c = crc16(txb) ^ {15'h0000, flip};
      put_byte(c[7:0]);
      put_byte(c[15:8]);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic pulse();
      #(HALF) LINK_CLK = 1'h1;
      #(HALF) LINK_CLK = 1'h0;
   endtask
   // Oversized frames are only sent when a scenario asks for one.
   task automatic frame();
      #40;
      LINK_FRAME = 1'h1;
      bq.push_front(start_val);
      foreach (bq[i]) begin
         LINK_RX = bq[i];
         LINK_NOINFO = (i == ni_at);
         pulse();
      end
      #(HALF) LINK_FRAME = 1'h0;
      // The data line carries no value between frames, so it must not echo the last bit.
      LINK_RX = ~LINK_RX;
      LINK_NOINFO = 1'h0;
      bq.delete();
      txb.delete();
      start_val = 1'h1;
      ni_at = -1;
   endtask
   // The clock runs only until the answer is over, so no new command overlaps it.
   task automatic listen();
      logic got[$];
      int idle;
      rsp.delete();
      idle = 0;
      #40;
      for (int n = 0; n < 400 && idle < 4; n++) begin
         pulse();
         if (LINK_TX_FRAME === 1'h1) got.push_back(LINK_TX_DATA);
         else if (got.size() > 0) idle = 4;
         else idle++;
      end
      rsp_bad = (got.size() > 307) || (got.size() > 0 &&
                 (got[0] !== 1'h1 || (got.size() - 1) % 9 != 0));
      for (int j = 1; j + 8 < got.size(); j += 9) begin
         logic [8:0] w;
         for (int k = 0; k < 9; k++) w[k] = got[j + k];
         if (^w !== 1'h1) rsp_bad = 1'h1;
         rsp.push_back(w[7:0]);
      end
   endtask
endmodule
`default_nettype wire

// *** dv/test_contactless_tag_activation_fsm.sv ***
// Self-checking bench of the tag activation block driven by a reader model.
`include "tga_defines.svh"
`default_nettype none
module test_contactless_tag_activation_fsm
   import tga_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   // Identifier and password values are arbitrary.
   localparam logic [55:0] UID = 56'h66_55_44_33_22_11_0A;
   localparam logic [31:0] PWD = 32'hA5C3_1E07;
   logic [31:0] pwd_value = PWD;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   wire logic link_clk, link_frame, link_rx, link_noinfo;
   logic tx_frame, tx_data, mem_valid, mem_auth;
   logic [7:0] mem_op, mem_arg;
   logic [2:0] tag_state;
   int n_mismatch = 0;
   int cmp_count = 0;
   int mem_seen = 0;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) if (mem_valid === 1'h1) mem_seen <= mem_seen + 1;
   tga_tag #(.UID(UID), .ATQA(16'h0044), .SAK_CL1(8'h04), .SAK_CL2(8'h00)) DUT (
      .CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .LINK_FRAME(link_frame),
      .LINK_RX(link_rx), .LINK_NOINFO(link_noinfo), .LINK_TX_FRAME(tx_frame),
      .LINK_TX_DATA(tx_data), .PWD_VALUE(pwd_value), .MEM_CMD_VALID(mem_valid),
      .MEM_CMD_OP(mem_op), .MEM_CMD_ARG(mem_arg), .MEM_CMD_AUTH(mem_auth), .TAG_STATE(tag_state));
   tga_reader_model rd (.LINK_CLK(link_clk), .LINK_FRAME(link_frame), .LINK_RX(link_rx),
      .LINK_NOINFO(link_noinfo), .LINK_TX_FRAME(tx_frame), .LINK_TX_DATA(tx_data));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic st(input tga_state_t e);
      chk(32'(tag_state), 32'(e));
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      #1 sys_rst = 1'h1;
      repeat (8) @(posedge core_clk);
      #1 sys_rst = 1'h0;
      repeat (3) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] cbyte(input logic two, input int k);
      logic [7:0] r[5];
      if (two) r = '{UID[31:24], UID[39:32], UID[47:40], UID[55:48], 8'h00};
      else r = '{`TGA_CASCADE_TAG, UID[7:0], UID[15:8], UID[23:16], 8'h00};
      r[4] = r[0] ^ r[1] ^ r[2] ^ r[3];
      return r[k];
   endfunction
   task automatic xfer();
      rd.frame();
      rd.listen();
      chk(32'(rd.rsp_bad), 32'h0);
   endtask
   task automatic short_cmd(input logic [7:0] c);
      rd.put_short(c);
      xfer();
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic crc);
      rd.put_byte(c);
      rd.put_byte(a);
      if (crc) rd.put_crc();
      xfer();
   endtask
   task automatic sel(input logic two);
      rd.put_byte(two ? `TGA_CMD_CL2 : `TGA_CMD_CL1);
      rd.put_byte(`TGA_NVB_SELECT);
      for (int k = 0; k < 5; k++) rd.put_byte(cbyte(two, k));
      rd.put_crc();
      xfer();
   endtask
   task automatic pwd(input logic [31:0] p);
      rd.put_byte(`TGA_CMD_PWD_VERIFY);
      for (int k = 0; k < 4; k++) rd.put_byte(p[8*k +: 8]);
      rd.put_crc();
      xfer();
   endtask
   task automatic chk_uid(input logic two);
      chk(32'(rd.rsp.size()), 32'h5);
      for (int k = 0; k < 5; k++) chk(32'(rd.rsp[k]), 32'(cbyte(two, k)));
   endtask
   task automatic chk_sak(input logic [7:0] s);
      logic [7:0] q[$];
      q.push_back(s);
      chk(32'(rd.rsp[0]), 32'(s));
      chk(32'({rd.rsp[2], rd.rsp[1]}), 32'(rd.crc16(q)));
   endtask
   task automatic wake(input logic [7:0] c);
      short_cmd(c);
      st(TGA_READY1);
      chk(32'({rd.rsp[1], rd.rsp[0]}), 32'h0044);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_idle();
      st(TGA_IDLE);
      cmd(`TGA_CMD_HLTA, 8'h00, 1'h1);
      st(TGA_IDLE);
      cmd(`TGA_CMD_READ, 8'h00, 1'h1);
      st(TGA_IDLE);
      chk(32'(mem_seen), 32'h0);
      wake(`TGA_CMD_REQA);
   endtask
   task automatic s_cascade();
      cmd(`TGA_CMD_CL1, `TGA_NVB_ANTICOLL, 1'h0);
      chk_uid(1'h0);
      sel(1'h0);
      st(TGA_READY2);
      chk_sak(8'h04);
      cmd(`TGA_CMD_CL2, `TGA_NVB_ANTICOLL, 1'h0);
      chk_uid(1'h1);
      st(TGA_READY2);
      sel(1'h1);
      st(TGA_ACTIVE);
      chk_sak(8'h00);
   endtask
   task automatic s_active();
      int n;
      n = mem_seen;
      rd.put_byte(`TGA_CMD_WRITE);
      for (int k = 0; k < 15; k++) rd.put_byte(8'(k));
      rd.put_crc();
      xfer();
      chk(32'(mem_seen - n), 32'h1);
      chk({8'h00, mem_op, mem_arg, 7'h00, mem_auth}, {8'h00, `TGA_CMD_WRITE, 16'h0000});
      pwd(PWD);
      st(TGA_AUTH);
      cmd(`TGA_CMD_READ, 8'h2C, 1'h1);
      chk({8'h00, mem_op, mem_arg, 7'h00, mem_auth}, {8'h00, `TGA_CMD_READ, 16'h2C01});
      cmd(`TGA_CMD_HLTA, 8'h00, 1'h1);
      st(TGA_HALT);
   endtask
   task automatic s_halt();
      short_cmd(`TGA_CMD_REQA);
      st(TGA_HALT);
      cmd(`TGA_CMD_READ, 8'h00, 1'h1);
      st(TGA_HALT);
      wake(`TGA_CMD_WUPA);
      cmd(`TGA_CMD_CL2, `TGA_NVB_ANTICOLL, 1'h0);
      st(TGA_HALT);
      wake(`TGA_CMD_WUPA);
      cmd(`TGA_CMD_READ, 8'h00, 1'h1);
      st(TGA_ACTIVE);
      rd.put_byte(`TGA_CMD_HLTA);
      rd.put_byte(8'h00);
      rd.put_crc(1'h1);
      xfer();
      st(TGA_HALT);
      wake(`TGA_CMD_WUPA);
      sel(1'h0);
      cmd(`TGA_CMD_READ, 8'h00, 1'h1);
      st(TGA_ACTIVE);
      cmd(`TGA_CMD_HLTA, 8'h00, 1'h1);
      st(TGA_HALT);
      wake(`TGA_CMD_WUPA);
      sel(1'h0);
      rd.ni_at = 12;
      cmd(`TGA_CMD_CL2, `TGA_NVB_ANTICOLL, 1'h0);
      st(TGA_HALT);
      wake(`TGA_CMD_WUPA);
      sel(1'h0);
      sel(1'h1);
      pwd(~PWD);
      st(TGA_HALT);
   endtask
   task automatic s_errors();
      int n;
      do_reset();
      st(TGA_IDLE);
      wake(`TGA_CMD_REQA);
      rd.start_val = 1'h0;
      cmd(`TGA_CMD_CL1, `TGA_NVB_ANTICOLL, 1'h0);
      st(TGA_IDLE);
      wake(`TGA_CMD_REQA);
      rd.put_byte(`TGA_CMD_READ, 1'h1);
      rd.put_byte(8'h00);
      rd.put_crc();
      xfer();
      st(TGA_IDLE);
      wake(`TGA_CMD_REQA);
      sel(1'h0);
      sel(1'h1);
      n = mem_seen;
      rd.put_byte(`TGA_CMD_WRITE);
      for (int k = 0; k < 16; k++) rd.put_byte(8'(k));
      rd.put_crc();
      xfer();
      st(TGA_IDLE);
      chk(32'(mem_seen - n), 32'h0);
      wake(`TGA_CMD_REQA);
      sel(1'h0);
      sel(1'h1);
      // A new stored password must take effect without a reset.
      @(posedge core_clk);
      #1 pwd_value = ~PWD;
      pwd(~PWD);
      st(TGA_AUTH);
      short_cmd(`TGA_CMD_REQA);
      st(TGA_IDLE);
   endtask
   initial begin
      do_reset();
      s_idle();
      s_cascade();
      s_active();
      s_halt();
      s_errors();
      end_sim();
   end
endmodule
`default_nettype wire
